/* verilog/ir_codec_pkg.sv */
// constants, states and state layout for the serial pulse codec
package ir_codec_pkg;
    // ------------------------------------------------------------
    // clock and timebase
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 25;
    localparam int OVERSAMPLE = 16;
    // 16x tick divisors: 25 MHz / (16 * rate), rounded to nearest
    localparam logic [7:0] DIV_9600 = 8'hA3;
    localparam logic [7:0] DIV_115200 = 8'h0E;
    localparam logic [7:0] DIV_ONE = 8'h01;
    // ------------------------------------------------------------
    // bit slot layout, in 16x ticks
    // ------------------------------------------------------------
    localparam logic [3:0] TICK_FIRST = 4'h0;
    localparam logic [3:0] TICK_MID = 4'h8;
    localparam logic [3:0] TICK_LAST = 4'hF;
    localparam logic [3:0] BIT_FIRST = 4'h0;
    localparam logic [3:0] BIT_DATA_LAST = 4'h8;
    localparam logic [3:0] BIT_STOP = 4'h9;
    localparam int DATA_BITS = 8;
    localparam int FIFO_DEPTH = 8;
    // ------------------------------------------------------------
    // pulse widths
    // ------------------------------------------------------------
    // 3/16 of a bit slot
    localparam logic [5:0] PULSE_TICKS = 6'h03;
    // 3/16 of the 115.2 kbit/s slot, rounded up to whole cycles
    localparam int SHORT_PULSE_NS = 1628;
    localparam int SHORT_PULSE_CYC = (SHORT_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam logic [5:0] SHORT_PULSE_LOAD = 6'(SHORT_PULSE_CYC);
    localparam logic [5:0] PW_LAST = 6'h01;
    // ------------------------------------------------------------
    // receive latency allowances after own transmission
    // ------------------------------------------------------------
    localparam int LAT_STD_US = 10000;
    localparam int LAT_LP_US = 500;
    localparam int LAT_HS_US = 100;
    localparam int LAT_HS_CYC = LAT_HS_US * CLK_MHZ;
    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_RUN = 2'b10} tx_state_e;
    typedef enum logic [1:0] {IN_IDLE = 2'b01, IN_RUN = 2'b10} in_state_e;

    typedef struct packed {
        logic [7:0] div;
        tx_state_e tx_state;
        logic [9:0] tx_shift;
        logic [3:0] tx_tick;
        logic [3:0] tx_bit;
        logic [5:0] pw;
        logic pw_short;
        logic ir_tx;
        in_state_e in_state;
        logic [3:0] in_tick;
        logic [3:0] in_bit;
        logic [7:0] in_shift;
        logic txd_q;
        logic push;
        logic [7:0] push_data;
        logic rx_busy;
        logic [3:0] rx_tick;
        logic [3:0] rx_bit;
        logic rx_next_zero;
        logic rxd;
        logic irrx_q;
    } codec_s;
endpackage

/* verilog/ir_char_fifo.sv */
// small character fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module ir_char_fifo
    import ir_codec_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [CW-1:0] count;
    } fifo_s;

    fifo_s st;
    fifo_s next_st;
    logic do_push;
    logic do_pop;

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction

    assign in_ready = (st.count != FULL);
    assign out_valid = (st.count != '0);
    assign out_data = st.mem[st.rptr];
    assign do_push = ce && in_valid && in_ready;
    assign do_pop = ce && out_ready && out_valid;

    always_comb
    begin
        next_st = st;
        if (do_push)
        begin
            next_st.mem[st.wptr] = in_data;
            next_st.wptr = ptr_inc(st.wptr);
        end
        if (do_pop)
            next_st.rptr = ptr_inc(st.rptr);
        if (do_push && !do_pop)
            next_st.count = CW'(st.count + 1'b1);
        else if (do_pop && !do_push)
            next_st.count = CW'(st.count - 1'b1);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            st <= '0;
        else if (ce)
            st <= next_st;
    end
endmodule
`default_nettype wire

/* verilog/ir_pulse_codec.sv */
// uart to optical pulse encoder and decoder, rates up to 115.2 kbit/s
//
// Notes on behaviour
// RL1: the uart delivers start bit, eight data bits, no parity, one stop bit.
// RL2: a sent pulse lasts three sixteenths of the current bit period.
// RL3: below 115.2 kbit/s a fixed short pulse of 3/16 of the 115.2 kbit/s period may be used.
// RL4: each sent pulse begins at the middle of its bit period.
// RL5: a zero is one pulse, a one is no pulse, and the decoder maps back the same way.
// RL6: 9.6 kbit/s operation is always supported.
// RL7: the decoder accepts pulses of the nominal width and also longer ones.
// RL8: this coding applies to every rate up to and including 115.2 kbit/s.
// RL9: after own transmission the receiver is ready well inside 10 ms, 0.5 ms or 0.1 ms.
// RL10: the decoder realigns on each start pulse and rests at one with no pulses.
`timescale 1ns/1ps
`default_nettype none
module ir_pulse_codec
    import ir_codec_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic CE,
    input wire logic [7:0] DIV16,
    input wire logic SHORT_PULSE,
    input wire logic UART_TXD,
    output logic TX_READY,
    output logic UART_RXD,
    output logic IR_TX,
    input wire logic IR_RX,
    output logic TX_BUSY
);
    codec_s st;
    codec_s next_st;
    logic [7:0] div_top;
    logic tick;
    logic rx_gate;
    logic rx_rise;
    logic fifo_valid;
    logic fifo_pop;
    logic [7:0] fifo_data;

    function automatic logic [3:0] inc4(input logic [3:0] v);
        inc4 = 4'(v + 1'b1);
    endfunction

    // ------------------------------------------------------------
    // timebase
    // ------------------------------------------------------------
    // a zero divisor would stall everything, so treat it as one
    assign div_top = 8'((DIV16 == '0) ? DIV_ONE : DIV16) - DIV_ONE;
    assign tick = (st.div == div_top); // [RL6] [RL8]

    // own echo is blanked only while sending, so the receiver is
    // armed one cycle after the frame, far inside any latency limit
    assign rx_gate = (st.tx_state != TX_IDLE) || st.ir_tx; // [RL9]
    assign rx_rise = IR_RX && !st.irrx_q; // [RL7]
    assign fifo_pop = CE && tick && (st.tx_state == TX_IDLE) && fifo_valid;

    ir_char_fifo #(
        .WIDTH(DATA_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(CLOCK),
        .rst(RST),
        .ce(CE),
        .in_valid(st.push),
        .in_ready(TX_READY),
        .in_data(st.push_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    always_comb
    begin
        next_st = st;
        next_st.div = tick ? 8'h00 : 8'(st.div + 1'b1);
        next_st.txd_q = UART_TXD;
        next_st.irrx_q = IR_RX;
        next_st.push = 1'b0;

        // ------------------------------------------------------------
        // uart character capture, 16x sampled, middle of each bit
        // ------------------------------------------------------------
        case (st.in_state)
            IN_IDLE:
            begin
                if (st.txd_q && !UART_TXD)
                begin
                    next_st.in_state = IN_RUN;
                    next_st.in_tick = TICK_FIRST;
                    next_st.in_bit = BIT_FIRST;
                end
            end
            IN_RUN:
            begin
                if (tick)
                begin
                    next_st.in_tick = inc4(st.in_tick);
                    if (st.in_tick == TICK_MID)
                    begin
                        next_st.in_bit = inc4(st.in_bit);
                        if (st.in_bit == BIT_FIRST && UART_TXD)
                            next_st.in_state = IN_IDLE;
                        else if (st.in_bit == BIT_STOP)
                        begin
                            // framing error drops the character
                            next_st.in_state = IN_IDLE;
                            next_st.push = UART_TXD; // [RL1]
                            next_st.push_data = st.in_shift;
                        end
                        else if (st.in_bit != BIT_FIRST)
                            next_st.in_shift = {UART_TXD, st.in_shift[7:1]};
                    end
                end
            end
            default:
                next_st.in_state = IN_IDLE;
        endcase

        // ------------------------------------------------------------
        // pulse width timer
        // ------------------------------------------------------------
        if (st.ir_tx && (st.pw_short || tick))
        begin
            next_st.pw = 6'(st.pw - 1'b1);
            if (st.pw == PW_LAST)
                next_st.ir_tx = 1'b0; // [RL2] [RL3]
        end

        // ------------------------------------------------------------
        // transmit encoder
        // ------------------------------------------------------------
        case (st.tx_state)
            TX_IDLE:
            begin
                if (fifo_pop)
                begin
                    next_st.tx_state = TX_RUN;
                    next_st.tx_shift = {1'b1, fifo_data, 1'b0};
                    next_st.tx_tick = TICK_FIRST;
                    next_st.tx_bit = BIT_FIRST;
                end
            end
            TX_RUN:
            begin
                if (tick)
                begin
                    next_st.tx_tick = inc4(st.tx_tick);
                    // zero gets a pulse, one gets none, starting mid slot
                    // fire as the slot enters its middle tick, not one tick later
                    if (inc4(st.tx_tick) == TICK_MID && !st.tx_shift[0]) // [RL4] [RL5]
                    begin
                        next_st.ir_tx = 1'b1;
                        next_st.pw_short = SHORT_PULSE; // [RL3]
                        next_st.pw = SHORT_PULSE ? SHORT_PULSE_LOAD : PULSE_TICKS; // [RL2]
                    end
                    if (st.tx_tick == TICK_LAST) // [RL8]
                    begin
                        next_st.tx_shift = {1'b1, st.tx_shift[9:1]};
                        next_st.tx_bit = inc4(st.tx_bit);
                        if (st.tx_bit == BIT_STOP)
                            next_st.tx_state = TX_IDLE;
                    end
                end
            end
            default:
                next_st.tx_state = TX_IDLE;
        endcase

        // ------------------------------------------------------------
        // receive decoder
        // ------------------------------------------------------------
        if (!st.rx_busy)
        begin
            next_st.rxd = 1'b1; // [RL10]
            if (rx_rise && !rx_gate)
            begin
                // start pulse sets the slot grid for the whole frame
                next_st.rx_busy = 1'b1; // [RL10]
                next_st.rx_tick = TICK_FIRST;
                next_st.rx_bit = BIT_FIRST;
                next_st.rx_next_zero = 1'b0;
                next_st.rxd = 1'b0; // [RL5]
            end
        end
        else
        begin
            // only the leading edge counts, so long pulses decode fine
            if (rx_rise) // [RL7]
            begin
                if (st.rx_tick < TICK_MID)
                    next_st.rxd = 1'b0; // [RL5]
                else
                    next_st.rx_next_zero = 1'b1;
            end
            if (tick)
            begin
                next_st.rx_tick = inc4(st.rx_tick);
                if (st.rx_tick == TICK_LAST)
                begin
                    next_st.rx_bit = inc4(st.rx_bit);
                    next_st.rx_next_zero = 1'b0;
                    next_st.rxd = !(st.rx_next_zero || (rx_rise && st.rx_tick >= TICK_MID));
                    if (st.rx_bit == BIT_STOP)
                    begin
                        next_st.rx_busy = 1'b0;
                        next_st.rxd = 1'b1;
                    end
                end
            end
        end
    end

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            st <= '0;
            st.tx_state <= TX_IDLE;
            st.in_state <= IN_IDLE;
            st.txd_q <= 1'b1;
            st.rxd <= 1'b1;
        end
        else if (CE)
            st <= next_st;
    end

    assign UART_RXD = st.rxd;
    assign IR_TX = st.ir_tx;
    assign TX_BUSY = (st.tx_state != TX_IDLE);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [5:0] hi_cyc;
    logic [5:0] hi_tick;
    logic [7:0] gap;
    logic seen_tick;

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            hi_cyc <= '0;
            hi_tick <= '0;
            gap <= '0;
            seen_tick <= 1'b0;
        end
        else if (CE)
        begin
            hi_cyc <= st.ir_tx ? 6'(hi_cyc + 1'b1) : 6'h00;
            hi_tick <= !st.ir_tx ? 6'h00 : (tick ? 6'(hi_tick + 1'b1) : hi_tick);
            gap <= tick ? 8'h01 : 8'(gap + 1'b1);
            seen_tick <= seen_tick || tick;
        end
    end

    a_pulse_mid_start: assert property (@(posedge CLOCK) disable iff (RST) // [RL4]
        $rose(st.ir_tx) |-> st.tx_tick == TICK_MID && $past(tick))
        else $error("pulse did not start mid slot");
    a_pulse_zero_only: assert property (@(posedge CLOCK) disable iff (RST) // [RL5]
        $rose(st.ir_tx) |-> !$past(st.tx_shift[0]))
        else $error("pulse sent for a one bit");
    a_pulse_std_width: assert property (@(posedge CLOCK) disable iff (RST) // [RL2]
        ($fell(st.ir_tx) && !st.pw_short) |-> hi_tick == PULSE_TICKS)
        else $error("standard pulse not three ticks");
    a_pulse_short_width: assert property (@(posedge CLOCK) disable iff (RST) // [RL3]
        ($fell(st.ir_tx) && st.pw_short) |-> hi_cyc == SHORT_PULSE_LOAD)
        else $error("short pulse width wrong");
    a_rx_start_zero: assert property (@(posedge CLOCK) disable iff (RST) // [RL5] [RL10]
        (CE && !st.rx_busy && rx_rise && !rx_gate) |=> !UART_RXD && st.rx_busy)
        else $error("start pulse not decoded as zero");
    a_rx_idle_one: assert property (@(posedge CLOCK) disable iff (RST) // [RL10]
        !st.rx_busy |-> UART_RXD)
        else $error("receive output not one while idle");
    a_rx_ready_latency: assert property (@(posedge CLOCK) disable iff (RST) // [RL9]
        $fell(TX_BUSY) |-> ##[0:1] !rx_gate)
        else $error("receiver not armed after transmit");
    a_slot_sixteen: assert property (@(posedge CLOCK) disable iff (RST) // [RL8]
        (st.tx_state == TX_RUN && $past(st.tx_state) == TX_RUN && $changed(st.tx_bit))
        |-> $past(st.tx_tick) == TICK_LAST)
        else $error("bit slot not sixteen ticks");
    a_rate_low_tick: assert property (@(posedge CLOCK) disable iff (RST) // [RL6]
        (CE && tick && seen_tick && DIV16 == DIV_9600 && $stable(DIV16)) |-> gap == DIV_9600)
        else $error("9.6 kbit/s tick spacing wrong");
endmodule
`default_nettype wire

/* tb/uart_partner.sv */
// uart model on the serial side of the pulse codec
`timescale 1ns/1ps
`default_nettype none
module uart_partner
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] bit_cyc,
    input wire logic send_valid,
    input wire logic [7:0] send_data,
    output logic send_ready,
    output logic txd,
    input wire logic rxd,
    output logic rx_valid,
    output logic [8:0] rx_data
);
    logic [9:0] fr;
    logic [9:0] got;
    initial
    begin
        send_ready = 1'b1;
        txd = 1'b1;
        rx_valid = 1'b0;
        rx_data = 9'h000;
    end
    // ----------------
    // sender
    // ----------------
    always
    begin
        @(posedge clk);
        if (send_valid === 1'b1 && send_ready === 1'b1 && rst === 1'b0)
        begin
            fr = {1'b1, send_data, 1'b0};
            send_ready <= 1'b0;
            for (int k = 0; k < 10; k++)
            begin
                #1 txd = fr[k];
                repeat (bit_cyc) @(posedge clk);
            end
            send_ready <= 1'b1;
        end
    end
    // ----------------
    // receiver
    // ----------------
    // samples mid bit; reports {stop, data} one cycle
    always
    begin
        @(posedge clk);
        rx_valid <= 1'b0;
        if (rxd === 1'b0 && rst === 1'b0)
        begin
            repeat (bit_cyc / 2) @(posedge clk);
            for (int k = 0; k < 10; k++)
            begin
                got[k] = rxd;
                if (k < 9)
                    repeat (bit_cyc) @(posedge clk);
            end
            rx_data <= got[9:1];
            rx_valid <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* tb/test_ir_pulse_codec.sv */
// self-checking bench for the serial pulse codec
`timescale 1ns/1ps
`default_nettype none
module test_ir_pulse_codec;
    import ir_codec_pkg::*;
    logic CLOCK = 1'b0;
    logic RST = 1'b1;
    logic [7:0] DIV16 = DIV_115200;
    logic SHORT_PULSE = 1'b0;
    logic UART_TXD, TX_READY, UART_RXD, IR_TX, IR_RX, TX_BUSY;
    logic ir_drv = 1'b0;
    logic echo = 1'b0;
    logic s_valid = 1'b0;
    logic [7:0] s_data = 8'h00;
    logic s_ready, r_valid;
    logic [8:0] r_data;
    logic CE = 1'b1;
    logic busy_q = 1'b0;
    int fail_count = 0;
    int n_tests = 0;
    int seed = 67030;
    int cyc = 0;
    int busy_at = 0;
    int p, w;
    logic [7:0] tx_q[$], rx_q[$];
    assign p = 16 * DIV16;
    assign w = SHORT_PULSE ? SHORT_PULSE_CYC : 3 * DIV16;
    // echo mode puts the emitter back on the detector
    assign IR_RX = echo ? IR_TX : ir_drv;
    always #20 CLOCK = ~CLOCK;
    ir_pulse_codec i_ir_pulse_codec (.CLOCK(CLOCK), .RST(RST), .CE(CE),
        .DIV16(DIV16), .SHORT_PULSE(SHORT_PULSE), .UART_TXD(UART_TXD),
        .TX_READY(TX_READY), .UART_RXD(UART_RXD), .IR_TX(IR_TX),
        .IR_RX(IR_RX), .TX_BUSY(TX_BUSY));
    uart_partner i_uart_partner (.clk(CLOCK), .rst(RST), .bit_cyc(16'(p)),
        .send_valid(s_valid), .send_data(s_data), .send_ready(s_ready),
        .txd(UART_TXD), .rxd(UART_RXD), .rx_valid(r_valid), .rx_data(r_data));
    // ----------------
    // checking
    // ----------------
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %0h seen %0h", n, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge CLOCK)
    begin
        cyc <= cyc + 1;
        busy_q <= TX_BUSY;
        if (TX_BUSY === 1'b1 && busy_q === 1'b0)
            busy_at <= cyc;
    end
    // every cycle from the start pulse to one pulse width past mid stop slot is compared, so a late or wide pulse shows
    always
    begin : tx_mon
        int bad, last, pp, ww;
        logic s;
        logic [9:0] f;
        @(posedge CLOCK iff IR_TX === 1'b1);
        pp = p;
        ww = w;
        bad = 0;
        if (busy_at != last && cyc - busy_at < pp)
            chk("mid slot", cyc - busy_at, pp / 2);
        last = busy_at;
        for (int c = 0; c <= 9 * pp + ww; c++)
        begin
            if (c % pp == 0)
            begin
                s = IR_TX;
                f[c / pp] = ~IR_TX;
            end
            bad += (IR_TX !== ((c % pp < ww) ? s : 1'b0));
            @(posedge CLOCK);
        end
        chk("pulse shape", bad, 0);
        chk("tx frame", f, tx_q.size() ? {1'b1, tx_q.pop_front(), 1'b0} : 10'h3FF);
    end
    always @(posedge CLOCK)
        if (r_valid === 1'b1)
            chk("rx", r_data, rx_q.size() ? {1'b1, rx_q.pop_front()} : 9'h0);
    // ----------------
    // drivers
    // ----------------
    task automatic uart_send(input logic [7:0] b);
        @(posedge CLOCK);
        #1 s_valid = 1'b1;
        s_data = b;
        tx_q.push_back(b);
        do
            @(posedge CLOCK);
        while (s_ready !== 1'b1);
        #1 s_valid = 1'b0;
        chk("ready", TX_READY, 1'b1);
    endtask
    task automatic ir_send(input logic [7:0] b, input int pw);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        rx_q.push_back(b);
        for (int k = 0; k < 10; k++)
        begin
            @(posedge CLOCK);
            #1 ir_drv = ~f[k];
            repeat (pw) @(posedge CLOCK);
            #1 ir_drv = 1'b0;
            repeat (p - pw - 1) @(posedge CLOCK);
        end
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 60000 && !(tx_q.size() == 0 && TX_BUSY === 1'b0 && IR_TX === 1'b0); i++)
            @(posedge CLOCK);
        #1;
    endtask
    // ----------------
    // sequence
    // ----------------
    initial
    begin
        repeat (4) @(posedge CLOCK);
        #1;
        chk("reset", {IR_TX, UART_RXD, TX_BUSY, TX_READY}, 4'b0101);
        RST = 1'b0;
        // a detector pulse while the enable is low must leave no trace
        CE = 1'b0;
        ir_drv = 1'b1;
        repeat (8) @(posedge CLOCK);
        #1 ir_drv = 1'b0;
        chk("freeze", UART_RXD, 1'b1);
        repeat (4) @(posedge CLOCK);
        #1 CE = 1'b1;
        repeat (4) @(posedge CLOCK);
        #1;
        chk("thaw", {UART_RXD, TX_BUSY, IR_TX}, 3'b100);
        echo = 1'b1;
        for (int s = 0; s < 2; s++)
        begin
            SHORT_PULSE = 1'(s);
            for (int i = 0; i < 4; i++)
                uart_send(i == 0 ? 8'h00 : i == 1 ? 8'hFF : 8'($random(seed)));
            wait_idle();
            chk("idle", {TX_BUSY, IR_TX, TX_READY}, 3'b001);
        end
        echo = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            ir_send(8'($random(seed)), ((i % 2) * 7 + 3) * DIV16);
            repeat (p / 2 + ($random(seed) & 255)) @(posedge CLOCK);
            #1;
        end
        chk("rx idle", UART_RXD, 1'b1);
        DIV16 = DIV_9600;
        echo = 1'b1;
        uart_send(8'($random(seed)));
        wait_idle();
        chk("left", tx_q.size() + rx_q.size(), 0);
        report_and_stop();
    end
    initial
    begin
        #(95000 * 40);
        fail_count++;
        $display("[FAIL] watchdog expected end seen timeout");
        report_and_stop();
    end
endmodule
`default_nettype wire
